// [design/ctep_timer.sv]
/*
 * Cascaded 16-bit timer, event counter and 12-bit PWM with an Avalon-MM slave.
 * Assumes the event pin is synchronous to ref_clk and kept slow enough by its source.
 */
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`include "ctep_map.svh"
module ctep_timer (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Avalon-MM slave.
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Pins.
	input wire logic timer_in_pin,
	output logic pwm_output_pin,
	output logic irq
);
	import ctep_pkg::*;

	logic [7:0] pair_control_reg;
	logic [7:0] upper_mode_reg;
	logic [7:0] system_control_reg;
	ctep_pkg::ctep_byte_t pwm_high_reg;
	logic [15:0] low_word;
	logic wr_low;
	logic [15:0] cmp_active;
	logic [11:0] pwm_active;
	logic [15:0] cmp_buf;
	logic [11:0] pwm_buf;
	logic cmp_pend;
	logic pwm_pend;
	logic [15:0] count;
	logic [3:0] cycle_no;
	logic [10:0] pre_cnt;
	logic pin_q;
	logic extra_wait;
	logic [1:0] irq_stat;
	logic [1:0] irq_en;
	logic ack;
	ctep_pkg::ctep_mode_t mode;
	logic tick;
	logic upper_run;
	logic cascade_enable;
	logic [2:0] clock_select_field;
	logic [1:0] mode_select_field;
	logic external_clock_select;
	logic double_buffer_enable;
	logic wr_ctrl;
	logic wr_cmp_hi;
	logic wr_pwm_hi;
	logic cmp_hit;
	logic ovf;
	logic duty_hit;
	logic extra_now;

	assign upper_run = pair_control_reg[`CTEP_CTRL_UPPER_RUN];
	assign cascade_enable = pair_control_reg[`CTEP_CTRL_CASCADE];
	assign clock_select_field = upper_mode_reg[`CTEP_MODE_CLK_LSB +: 3];
	assign mode_select_field = upper_mode_reg[`CTEP_MODE_MSEL_LSB +: 2];
	assign external_clock_select = upper_mode_reg[`CTEP_MODE_EXT];
	assign double_buffer_enable = upper_mode_reg[`CTEP_MODE_DBE];

	// Address decode used by several processes.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign wr_ctrl = avs_write && ack && hit(avs_address, `CTEP_OFS_CTRL);
	assign wr_cmp_hi = avs_write && ack && hit(avs_address, `CTEP_OFS_CMP_HI);
	assign wr_pwm_hi = avs_write && ack && hit(avs_address, `CTEP_OFS_PWM_HI);
	assign wr_low = avs_write && ack &&
		(hit(avs_address, `CTEP_OFS_CMP_LO) || hit(avs_address, `CTEP_OFS_PWM_LO)); // RULE5 RULE13

	// Address bit 5 picks the pair. Reads lag a cycle, but a high write is taken two edges
	// after its address appears, so the staged low byte is already on low_word by then.
	ctep_regs u_low (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(wr_low),
		.wr_addr({1'b0, avs_address[5]}),
		.wr_data({8'h00, avs_writedata[7:0]}),
		.rd_addr({1'b0, avs_address[5]}),
		.rd_data(low_word)
	);

	// Mode decode: the lower timer's own settings never enter here.
	always_comb begin
		if (!cascade_enable || !upper_run) begin
			mode = CTEP_IDLE;
		end else if (mode_select_field == 2'b10) begin
			mode = CTEP_PWM; // RULE11 RULE3
		end else if (mode_select_field[1] == 1'b0 && external_clock_select) begin
			mode = CTEP_EVENT; // RULE4
		end else if (mode_select_field[1] == 1'b0) begin
			mode = CTEP_TIMER;
		end else begin
			mode = CTEP_IDLE;
		end
	end

	// Prescaler: free-running divider of ref_clk; low-speed source is modelled by it too.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pre_cnt <= 11'h000;
		end else begin
			pre_cnt <= pre_cnt + 11'h001;
		end
	end

	// Tick select: codes 1..6 pick one divider stage, code 0 one of two set by the system register, code 7 ticks every cycle.
	logic int_tick;
	always_comb begin
		unique case (clock_select_field)
			3'h0: int_tick = (system_control_reg[`CTEP_SYS_PRESRC] ||
				system_control_reg[`CTEP_SYS_SLOW]) ? (pre_cnt[3:0] == 4'hF) :
				(pre_cnt == 11'h7FF); // RULE1
			3'h1: int_tick = (pre_cnt[9:0] == 10'h3FF); // RULE1
			3'h2: int_tick = (pre_cnt[7:0] == 8'hFF);
			3'h3: int_tick = (pre_cnt[5:0] == 6'h3F);
			3'h4: int_tick = (pre_cnt[3:0] == 4'hF);
			3'h5: int_tick = (pre_cnt[1:0] == 2'h3);
			3'h6: int_tick = pre_cnt[0];
			3'h7: int_tick = 1'b1; // RULE1
		endcase
	end

	// External falling edge: pin phases of two cycles or more are guaranteed outside.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= timer_in_pin; // RULE10
		end
	end

	always_comb begin
		if (mode == CTEP_EVENT) begin
			tick = pin_q && !timer_in_pin; // RULE2
		end else if (mode == CTEP_PWM && external_clock_select) begin
			tick = pin_q && !timer_in_pin; // RULE12
		end else begin
			tick = int_tick; // RULE12
		end
	end

	// A match is taken on the tick that carries the count onto the compare value, so the
	// period is exactly the compare value in ticks and no tick is lost while clearing.
	assign cmp_hit = (mode == CTEP_TIMER || mode == CTEP_EVENT) && tick &&
		(count + 16'h0001 == cmp_active); // RULE8
	assign ovf = (mode == CTEP_PWM) && tick && (count[7:0] == 8'hFF);
	// Extra pulse placement over cycles 1..16, cycle_no holds cycle minus one.
	always_comb begin
		extra_now = 1'b0;
		if (pwm_active[3] && cycle_no[0]) extra_now = 1'b1; // RULE17
		if (pwm_active[2] && cycle_no[1:0] == 2'b10) extra_now = 1'b1; // RULE17
		if (pwm_active[1] && cycle_no[2:0] == 3'b100) extra_now = 1'b1; // RULE17
		if (pwm_active[0] && cycle_no == 4'h8) extra_now = 1'b1; // RULE17
	end
	assign duty_hit = (mode == CTEP_PWM) && tick &&
		(count[7:0] + 8'h01 == pwm_active[11:4]); // RULE14

	// Control and system registers.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pair_control_reg <= 8'h00;
			system_control_reg <= 8'h00;
		end else if (avs_write && ack) begin
			if (wr_ctrl) pair_control_reg <= avs_writedata[7:0];
			if (hit(avs_address, `CTEP_OFS_SYS)) system_control_reg <= avs_writedata[7:0];
		end
	end

	// Mode register locks while running.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			upper_mode_reg <= `CTEP_MODE_RESET;
		end else if (avs_write && ack && hit(avs_address, `CTEP_OFS_MODE) && !upper_run) begin
			upper_mode_reg <= avs_writedata[7:0]; // RULE7
		end
	end

	// Low halves are staged in the store; the high write moves the pair together.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_high_reg <= `CTEP_PWM_RESET;
		end else if (wr_pwm_hi) begin
			pwm_high_reg <= avs_writedata[7:0]; // RULE13
		end
	end

	// Compare buffer and active value.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmp_buf <= `CTEP_CMP_RESET;
			cmp_active <= `CTEP_CMP_RESET;
			cmp_pend <= 1'b0;
		end else if (wr_cmp_hi) begin
			cmp_buf <= {avs_writedata[7:0], low_word[7:0]}; // RULE5
			if (!double_buffer_enable || !upper_run) begin
				cmp_active <= {avs_writedata[7:0], low_word[7:0]}; // RULE6
				cmp_pend <= 1'b0;
			end else begin
				cmp_pend <= 1'b1; // RULE18
			end
		end else if (cmp_hit && cmp_pend) begin
			cmp_active <= cmp_buf; // RULE18
			cmp_pend <= 1'b0;
		end
	end

	// PWM buffer and active value; buffered writes load at the sixteenth overflow, others load at once.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_buf <= 12'hFFF;
			pwm_active <= 12'hFFF;
			pwm_pend <= 1'b0;
		end else if (wr_pwm_hi) begin
			pwm_buf <= {avs_writedata[3:0], low_word[7:0]}; // RULE13
			if (!double_buffer_enable || !upper_run) begin
				pwm_active <= {avs_writedata[3:0], low_word[7:0]}; // RULE6
				pwm_pend <= 1'b0;
			end else begin
				pwm_pend <= 1'b1;
			end
		end else if (ovf && cycle_no == 4'hF && pwm_pend) begin
			pwm_active <= pwm_buf; // RULE18
			pwm_pend <= 1'b0;
		end
	end

	// Up counter.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= 16'h0000;
			cycle_no <= 4'h0;
		end else if (mode == CTEP_IDLE) begin
			count <= 16'h0000; // RULE9
			cycle_no <= 4'h0;
		end else if (cmp_hit) begin
			count <= 16'h0000; // RULE8
		end else if (ovf) begin
			count <= 16'h0000; // RULE16
			cycle_no <= cycle_no + 4'h1;
		end else if (tick) begin
			count <= count + 16'h0001; // RULE2
		end
	end

	// PWM output: idle level from the mode register, inverted at duty, set back to the idle level at overflow.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_output_pin <= 1'b0;
			extra_wait <= 1'b0;
		end else if (mode != CTEP_PWM) begin
			pwm_output_pin <= upper_mode_reg[`CTEP_MODE_IDLE_LVL];
			extra_wait <= 1'b0;
		end else if (ovf) begin
			pwm_output_pin <= upper_mode_reg[`CTEP_MODE_IDLE_LVL]; // RULE16
			extra_wait <= 1'b0;
		end else if (duty_hit && extra_now) begin
			extra_wait <= 1'b1; // RULE15
		end else if (duty_hit || (extra_wait && tick)) begin
			pwm_output_pin <= !pwm_output_pin; // RULE15
			extra_wait <= 1'b0;
		end
	end

	// Interrupt status: set wins over a same-cycle clear.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_stat <= 2'b00;
			irq_en <= 2'b00;
		end else begin
			if (avs_write && ack && hit(avs_address, `CTEP_OFS_IRQ_EN)) begin
				irq_en <= avs_writedata[1:0];
			end
			irq_stat <= (irq_stat & ~((avs_write && ack && hit(avs_address, `CTEP_OFS_IRQ_CLR)) ?
				avs_writedata[1:0] : 2'b00)) |
				{cmp_hit || (ovf && cycle_no == 4'hF), ovf}; // RULE8 RULE16
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_en);
		end
	end

	// Bus slave: one wait cycle, then acknowledge with registered read data.
	assign ack = (avs_read || avs_write) && avs_waitrequest == 1'b0;
	logic req_seen;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_seen <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			req_seen <= (avs_read || avs_write) && !req_seen;
			avs_waitrequest <= !((avs_read || avs_write) && !req_seen);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read) begin
			unique case (avs_address)
				`CTEP_OFS_CTRL: avs_readdata <= {24'h000000, pair_control_reg};
				`CTEP_OFS_MODE: avs_readdata <= {24'h000000, upper_mode_reg};
				`CTEP_OFS_SYS: avs_readdata <= {24'h000000, system_control_reg};
				`CTEP_OFS_CMP_LO: avs_readdata <= {24'h000000, cmp_buf[7:0]};
				`CTEP_OFS_CMP_HI: avs_readdata <= {24'h000000, cmp_buf[15:8]};
				`CTEP_OFS_PWM_LO: avs_readdata <= {24'h000000, pwm_buf[7:0]};
				`CTEP_OFS_PWM_HI: avs_readdata <= {24'h000000, pwm_high_reg[7:4], pwm_buf[11:8]};
				`CTEP_OFS_IRQ_STAT: avs_readdata <= {30'h0, irq_stat};
				`CTEP_OFS_IRQ_EN: avs_readdata <= {30'h0, irq_en};
				`CTEP_OFS_COUNT: avs_readdata <= {16'h0000, count};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : ctep_timer

// [design/ctep_map.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the cascaded timer.
 * Assumes a 20 MHz system clock and word-aligned Avalon-MM byte addresses.
 */
// Summary of operation
// (RULE1) Three-bit clock select picks a prescaled tick; code 111 is the undivided clock.
// (RULE2) Event counting advances the 16-bit counter on each input falling edge.
// (RULE3) With cascade enabled only the upper timer settings matter; lower ones ignored.
// (RULE4) Modes 00 or 01 with external clock select give 16-bit event counting.
// (RULE5) Compare low byte written first; both bytes transfer when high byte is written.
// (RULE6) Double buffer is used only while its enable is one; else direct update.
// (RULE7) Mode register writes are ignored once the upper run bit is set.
// (RULE8) Counter equal to compare raises upper interrupt and clears counter to 0x0000.
// (RULE9) Clearing the upper run bit stops the counter and clears it to 0x0000.
// (RULE10) External input phases last two cycles at least; frequency at most clock/4.
// (RULE11) Mode 10 with cascade enabled selects the 12-bit PWM output mode.
// (RULE12) PWM counts the selected internal tick, or the pin when external select is one.
// (RULE13) PWM bits 11..8 from high register low nibble, 7..0 from low register.
// (RULE14) PWM duty has 8-bit resolution plus a 4-bit additional pulse control.
// (RULE15) Output inverts when counter low byte matches duty, one tick later if extra pulse.
// (RULE16) At count 256 counter clears, output inverts, lower irq; upper irq every 16th.
// (RULE17) Extra pulse bit0 cycle 9, bit1 5,13, bit2 3,7,11,15, bit3 even cycles.
// (RULE18) Double-buffered writes while running load on the next match or 16th overflow.
`ifndef CTEP_MAP_SVH
`define CTEP_MAP_SVH
`define CTEP_OFS_CTRL 8'h00
`define CTEP_OFS_MODE 8'h04
`define CTEP_OFS_CMP_LO 8'h08
`define CTEP_OFS_CMP_HI 8'h0C
`define CTEP_OFS_PWM_LO 8'h28
`define CTEP_OFS_PWM_HI 8'h2C
`define CTEP_OFS_SYS 8'h10
`define CTEP_OFS_IRQ_STAT 8'h14
`define CTEP_OFS_IRQ_EN 8'h18
`define CTEP_OFS_IRQ_CLR 8'h1C
`define CTEP_OFS_COUNT 8'h20
`define CTEP_CTRL_CASCADE 0
`define CTEP_CTRL_LOWER_RUN 1
`define CTEP_CTRL_UPPER_RUN 2
`define CTEP_MODE_CLK_LSB 0
`define CTEP_MODE_MSEL_LSB 4
`define CTEP_MODE_EXT 6
`define CTEP_MODE_DBE 7
`define CTEP_MODE_IDLE_LVL 3
`define CTEP_SYS_PRESRC 0
`define CTEP_SYS_SLOW 1
`define CTEP_PWM_RESET 8'hFF
`define CTEP_MODE_RESET 8'h00
`define CTEP_CMP_RESET 16'hFFFF
`define CTEP_PRE_LOW_SPEED 11
`define CTEP_PRE_HIGH 10
`endif

// [design/ctep_pkg.sv]
/*
 * Types shared by the cascaded timer.
 * Assumes inclusion before the timer modules.
 */
package ctep_pkg;
	typedef enum logic [3:0] {
		CTEP_IDLE = 4'b0001,
		CTEP_TIMER = 4'b0010,
		CTEP_EVENT = 4'b0100,
		CTEP_PWM = 4'b1000
	} ctep_mode_t;
	typedef logic [7:0] ctep_byte_t;
endpackage : ctep_pkg

// [design/ctep_regs.sv]
/*
 * Small register store holding the staged low halves of the compare and PWM pairs.
 * Assumes single-port writes and one-cycle registered reads.
 */
`timescale 1ns/100ps
`include "ctep_map.svh"
module ctep_regs (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Write side.
	input wire logic wr_en,
	input wire logic [1:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read side.
	input wire logic [1:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [0:3];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem[0] <= `CTEP_CMP_RESET;
			mem[1] <= 16'h0FFF;
			mem[2] <= 16'h0000;
			mem[3] <= 16'h0000;
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : ctep_regs

// [verification/ctep_evt_src.sv]
/* External event source driving the timer input pin.
   Assumes go is a one-cycle pulse and phase is two or more. */
`timescale 1ns/100ps
module ctep_evt_src (
	// Control from the bench.
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [7:0] phase,
	input wire logic [7:0] edges,
	// Pin side.
	output logic pin,
	output logic busy
);
	logic [7:0] left;
	logic [7:0] cnt;
	initial begin
		pin = 1'b1;
		busy = 1'b0;
		left = 8'h00;
		cnt = 8'h00;
	end
	// Each level is held for phase cycles, so no phase is ever shorter than two.
	always @(posedge ref_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			left <= edges;
			cnt <= 8'h01;
		end else if (busy && cnt < phase) begin
			cnt <= cnt + 8'h01;
		end else if (busy) begin
			cnt <= 8'h01;
			if (pin) begin
				pin <= 1'b0;
				left <= left - 8'h01;
			end else begin
				pin <= 1'b1;
				busy <= (left != 8'h00);
			end
		end
	end
endmodule : ctep_evt_src

// [verification/ctep_timer_chk.sv]
/* Checker for the timer bus and pins.
   Assumes it is bound to every ctep_timer instance. */
`timescale 1ns/100ps
`include "ctep_map.svh"
module ctep_timer_chk (
	// Clock, reset and bus.
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Pins.
	input wire logic timer_in_pin,
	input wire logic pwm_output_pin,
	input wire logic irq
);
	logic run_q;
	logic [7:0] mode_q;
	logic [1:0] en_q;
	logic wtk;
	assign wtk = avs_write && !avs_waitrequest;
	// Shadows of the written registers, so read data can be tied to its cause.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			run_q <= 1'b0;
			mode_q <= 8'h00;
			en_q <= 2'h0;
		end else if (wtk) begin
			if (avs_address == `CTEP_OFS_CTRL) run_q <= avs_writedata[2];
			if (avs_address == `CTEP_OFS_MODE && !run_q) mode_q <= avs_writedata[7:0];
			if (avs_address == `CTEP_OFS_IRQ_EN) en_q <= avs_writedata[1:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("waitrequest low without a request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	reset_state_a: assert property ($fell(rst) |-> avs_waitrequest && !irq && !pwm_output_pin)
		else $error("outputs not at reset level");
	unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	mode_lock_a: assert property (avs_read && !avs_waitrequest
		&& avs_address == `CTEP_OFS_MODE |-> avs_readdata[7:0] == mode_q)
		else $error("mode register changed while running");
	count_stop_a: assert property (avs_read && !avs_waitrequest
		&& avs_address == `CTEP_OFS_COUNT && !run_q && !$past(run_q) && !$past(run_q, 2)
		|-> avs_readdata[15:0] == 16'h0) else $error("stopped counter not zero");
	irq_mask_a: assert property (en_q == 2'h0 && $past(en_q) == 2'h0 |-> !irq)
		else $error("irq high while masked");
endmodule : ctep_timer_chk
bind ctep_timer ctep_timer_chk u_chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.timer_in_pin(timer_in_pin), .pwm_output_pin(pwm_output_pin), .irq(irq));

// [verification/tb_top.sv]
/* Self-checking bench for the cascaded timer.
   Assumes the event source model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`include "ctep_map.svh"
module tb_top;
	typedef struct {
		logic [31:0] m;
		logic [31:0] v;
	} ctep_exp_t;
	ctep_exp_t exp_q[$];
	ctep_exp_t ex;
	logic ref_clk;
	logic rst;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic timer_in_pin;
	logic pwm_output_pin;
	logic irq;
	logic ev_go;
	logic ev_busy;
	logic [7:0] ev_n;
	logic [7:0] ev_ph;
	logic [7:0] e;
	int mismatches;
	int cmp_count;
	int th;
	int tl;
	int r;
	ctep_timer dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer_in_pin(timer_in_pin),
		.pwm_output_pin(pwm_output_pin), .irq(irq));
	ctep_evt_src u_src (.ref_clk(ref_clk), .go(ev_go), .phase(ev_ph), .edges(ev_n),
		.pin(timer_in_pin), .busy(ev_busy));
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// The request is held until waitrequest is sampled low, then released.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 40) begin
			mismatches++;
			test_done();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		exp_q.push_back('{m, v});
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic pulse(input logic [7:0] n);
		int k;
		k = 0;
		@(posedge ref_clk);
		ev_go <= 1'b1;
		ev_n <= n;
		@(posedge ref_clk);
		ev_go <= 1'b0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (ev_busy !== 1'b0 && k < 200);
		if (k >= 200) begin
			mismatches++;
			test_done();
		end
	endtask : pulse
	task automatic wpin(input logic lvl, output int t);
		t = 0;
		// The pin is looked at on the falling edge, where it has settled.
		do begin
			@(negedge ref_clk);
			t++;
		end while (pwm_output_pin !== lvl && t < 3000);
		if (t >= 3000) begin
			mismatches++;
			test_done();
		end
	endtask : wpin
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Read results are compared against the oldest noted expectation.
	always @(posedge ref_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			ex = exp_q.pop_front();
			chk("readdata", avs_readdata & ex.m, ex.v);
		end
	end
	initial begin
		rst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		ev_go = 1'b0;
		ev_n = 8'h00;
		mismatches = 0;
		cmp_count = 0;
		r = $urandom(72);
		e = 8'(3 + $urandom % 6);
		ev_ph = 8'(2 + $urandom % 3);
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`CTEP_OFS_MODE, 32'hFF, 32'h00);
		rd(`CTEP_OFS_PWM_LO, 32'hFF, 32'hFF);
		rd(8'h30, 32'hFFFFFFFF, 32'h0);
		$display("test reset done");
		wr(`CTEP_OFS_MODE, 8'h40);
		wr(`CTEP_OFS_CMP_LO, 8'hFF);
		wr(`CTEP_OFS_CMP_HI, 8'h00);
		wr(`CTEP_OFS_IRQ_EN, 8'h02);
		wr(`CTEP_OFS_CTRL, 8'h05);
		pulse(e);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, {24'h0, e});
		wr(`CTEP_OFS_CMP_LO, e + 8'h02);
		pulse(8'h02);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, {24'h0, e + 8'h02});
		wr(`CTEP_OFS_CMP_LO, e + 8'h04);
		wr(`CTEP_OFS_CMP_HI, 8'h00);
		pulse(8'h02);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, 32'h0);
		chk("irq", irq, 32'h1);
		rd(`CTEP_OFS_IRQ_STAT, 32'h2, 32'h2);
		wr(`CTEP_OFS_IRQ_CLR, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 32'h0);
		pulse(8'h01);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, 32'h1);
		wr(`CTEP_OFS_MODE, 8'hC7);
		rd(`CTEP_OFS_MODE, 32'hFF, 32'h40);
		wr(`CTEP_OFS_CTRL, 8'h01);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, 32'h0);
		$display("test event done");
		wr(`CTEP_OFS_MODE, 8'hC0);
		wr(`CTEP_OFS_CMP_LO, 8'h06);
		wr(`CTEP_OFS_CMP_HI, 8'h00);
		wr(`CTEP_OFS_IRQ_EN, 8'h00);
		wr(`CTEP_OFS_CTRL, 8'h05);
		pulse(8'h02);
		wr(`CTEP_OFS_CMP_LO, 8'h03);
		wr(`CTEP_OFS_CMP_HI, 8'h00);
		pulse(8'h02);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, 32'h4);
		pulse(8'h05);
		rd(`CTEP_OFS_COUNT, 32'hFFFF, 32'h0);
		rd(`CTEP_OFS_IRQ_STAT, 32'h2, 32'h2);
		chk("irq", irq, 32'h0);
		wr(`CTEP_OFS_CTRL, 8'h01);
		wr(`CTEP_OFS_IRQ_CLR, 8'h03);
		$display("test buffer done");
		wr(`CTEP_OFS_MODE, 8'h07);
		wr(`CTEP_OFS_CMP_LO, 8'h10);
		wr(`CTEP_OFS_CMP_HI, 8'h00);
		wr(`CTEP_OFS_CTRL, 8'h05);
		repeat (40) @(posedge ref_clk);
		rd(`CTEP_OFS_COUNT, 32'hFFF0, 32'h0);
		rd(`CTEP_OFS_IRQ_STAT, 32'h2, 32'h2);
		wr(`CTEP_OFS_CTRL, 8'h01);
		wr(`CTEP_OFS_IRQ_CLR, 8'h03);
		$display("test timer done");
		for (int k = 0; k < 3; k++) begin
			wr(`CTEP_OFS_MODE, 8'h27 - 8'(k));
			wr(`CTEP_OFS_PWM_LO, 8'h00);
			wr(`CTEP_OFS_PWM_HI, 8'h04);
			rd(`CTEP_OFS_PWM_LO, 32'hFF, 32'h00);
			wr(`CTEP_OFS_CTRL, 8'h05);
			wpin(1'b1, th);
			wpin(1'b0, th);
			wpin(1'b1, tl);
			chk("pwm_high", th, 32'(192 << k));
			chk("pwm_period", th + tl, 32'(256 << k));
			rd(`CTEP_OFS_IRQ_STAT, 32'h1, 32'h1);
			wr(`CTEP_OFS_CTRL, 8'h01);
			wr(`CTEP_OFS_IRQ_CLR, 8'h03);
		end
		wr(`CTEP_OFS_MODE, 8'h27);
		wr(`CTEP_OFS_PWM_LO, 8'h08);
		wr(`CTEP_OFS_PWM_HI, 8'h04);
		wr(`CTEP_OFS_CTRL, 8'h05);
		wpin(1'b1, th);
		wpin(1'b0, th);
		wpin(1'b1, tl);
		wpin(1'b0, th);
		chk("pwm_extra_low", tl, 32'd65);
		chk("pwm_extra_high", th, 32'd191);
		wr(`CTEP_OFS_CTRL, 8'h01);
		$display("test pwm done");
		test_done();
	end
endmodule : tb_top
